/* core/ssw_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants for the supply supervisor and watchdog
// ----------------------------------------------------------------------------
package ssw_pkg;

  // clock: 100 MHz
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned NS_PER_MS       = 1000000;

  // reset stretch, nominal 200 ms (160 to 280 ms allowed)
  localparam int unsigned STRETCH_TIME_MS = 200;
  localparam int unsigned STRETCH_CYCLES  = STRETCH_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // watchdog timeout, nominal 1.60 s (1.00 to 2.25 s allowed)
  localparam int unsigned WDOG_TIME_MS    = 1600;
  localparam int unsigned WDOG_CYCLES     = WDOG_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // width of the cycle counters
  localparam int unsigned CNT_W           = 32;

  // bit positions in the synchronised input vector
  localparam int unsigned IN_W            = 5;
  localparam int unsigned IN_SUPPLY_LOW   = 0;
  localparam int unsigned IN_MANUAL_RST   = 1;
  localparam int unsigned IN_KICK         = 2;
  localparam int unsigned IN_PF_BELOW     = 3;
  localparam int unsigned IN_KICK_FLOAT   = 4;

  // synchroniser reset value: supply low, no manual reset, kick 0,
  // power fail seen, kick floating (safe, quiet state)
  localparam logic [IN_W-1:0] IN_RST_VAL  = 5'h1b;

  // reset values of the registered outputs
  localparam logic RST_N_RST_VAL          = 1'h0;
  localparam logic WDO_N_RST_VAL          = 1'h0;
  localparam logic PFO_N_RST_VAL          = 1'h0;

endpackage

/* core/ssw_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// two-flop synchroniser for the asynchronous pins
// ----------------------------------------------------------------------------
module ssw_sync #(
  parameter int unsigned            W       = ssw_pkg::IN_W,
  parameter logic [ssw_pkg::IN_W-1:0] RST_VAL = ssw_pkg::IN_RST_VAL
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  import ssw_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ssw_sync_state_t;

  ssw_sync_state_t st;
  ssw_sync_state_t next_st;

  // meta feeds only the second stage
  always_comb begin
    next_st      = st;
    next_st.meta = i_async;
    next_st.sync = st.meta;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= {RST_VAL[W-1:0], RST_VAL[W-1:0]};
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.sync;

endmodule

`default_nettype wire

/* core/ssw_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// saturating cycle counter, cleared while restart is high
// ----------------------------------------------------------------------------
module ssw_timer #(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  input  wire logic i_restart,
  output logic      o_expired
);
  import ssw_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             expired;
  } ssw_timer_state_t;

  ssw_timer_state_t st;
  ssw_timer_state_t next_st;

  // expired rises CYCLES edges after restart drops and stays until restart
  always_comb begin
    next_st = st;
    if (i_restart) begin
      next_st.count   = '0;
      next_st.expired = 1'h0;
    end else if (st.count < CNT_W'(CYCLES)) begin
      next_st.count   = CNT_W'(st.count + 32'h1);
      next_st.expired = (CNT_W'(st.count + 32'h1) >= CNT_W'(CYCLES));
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_expired = st.expired;

endmodule

`default_nettype wire

/* core/ssw_top.sv */
`timescale 1ns/1ps
`default_nettype none

module ssw_top #(
  parameter int unsigned STRETCH_CYCLES = ssw_pkg::STRETCH_CYCLES,
  parameter int unsigned WDOG_CYCLES    = ssw_pkg::WDOG_CYCLES
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  input  wire logic i_supply_low,
  input  wire logic i_manual_reset_n,
  input  wire logic i_watchdog_kick_in,
  input  wire logic i_watchdog_kick_float,
  input  wire logic i_power_fail_sense_in,
  output logic      o_reset_n,
  output logic      o_reset,
  output logic      o_watchdog_expired_n,
  output logic      o_power_fail_out_n
);
  import ssw_pkg::*;

  // --------------------------------------------------------------------------
  // input synchronisation
  // --------------------------------------------------------------------------

  logic [IN_W-1:0] pins_s;
  logic            supply_s;
  logic            mr_n_s;
  logic            kick_s;
  logic            pf_below_s;
  logic            float_s;

  // every pin is asynchronous to i_sys_clk, so all pass two flops
  ssw_sync #(
    .W       (IN_W),
    .RST_VAL (IN_RST_VAL)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_watchdog_kick_float, i_power_fail_sense_in, i_watchdog_kick_in,
                 i_manual_reset_n, i_supply_low}),
    .o_sync    (pins_s)
  );

  assign supply_s   = pins_s[IN_SUPPLY_LOW];
  assign mr_n_s     = pins_s[IN_MANUAL_RST];
  assign kick_s     = pins_s[IN_KICK];
  assign pf_below_s = pins_s[IN_PF_BELOW];
  assign float_s    = pins_s[IN_KICK_FLOAT];

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------

  typedef struct packed {
    logic reset_n;
    logic reset_hi;
    logic wdo_n;
    logic pfo_n;
    logic kick_prev;
  } ssw_top_state_t;

  ssw_top_state_t st;
  ssw_top_state_t next_st;

  logic hold_req;
  logic stretch_done;
  logic rst_act;
  logic kick_edge;
  logic wd_clear;
  logic wd_expired;

  // --------------------------------------------------------------------------
  // reset stretch
  // --------------------------------------------------------------------------

  // either source holds the stretch timer in restart, so any bounce on the
  // manual input simply restarts the full period
  assign hold_req = supply_s | ~mr_n_s;

  ssw_timer #(
    .CYCLES (STRETCH_CYCLES)
  ) u_stretch (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_restart (hold_req),
    .o_expired (stretch_done)
  );

  // the watchdog plays no part here; its output must be wired back to the
  // manual input externally to cause a reset
  assign rst_act = hold_req | ~stretch_done;

  // --------------------------------------------------------------------------
  // watchdog
  // --------------------------------------------------------------------------

  assign kick_edge = kick_s ^ st.kick_prev;

  // a floating input keeps the counter cleared, which disables the timeout
  assign wd_clear = kick_edge | rst_act | float_s;

  ssw_timer #(
    .CYCLES (WDOG_CYCLES)
  ) u_wdog (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_restart (wd_clear),
    .o_expired (wd_expired)
  );

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------

  // all outputs registered; both reset polarities come from one expression
  always_comb begin
    next_st           = st;
    next_st.reset_n   = ~rst_act;
    next_st.reset_hi  = rst_act;
    next_st.wdo_n     = ~(supply_s | wd_expired);
    next_st.pfo_n     = ~pf_below_s;
    next_st.kick_prev = kick_s;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st.reset_n   <= RST_N_RST_VAL;
      st.reset_hi  <= ~RST_N_RST_VAL;
      st.wdo_n     <= WDO_N_RST_VAL;
      st.pfo_n     <= PFO_N_RST_VAL;
      st.kick_prev <= IN_RST_VAL[IN_KICK];
    end else begin
      st <= next_st;
    end
  end

  assign o_reset_n            = st.reset_n;
  assign o_reset              = st.reset_hi;
  assign o_watchdog_expired_n = st.wdo_n;
  assign o_power_fail_out_n   = st.pfo_n;

  // --------------------------------------------------------------------------
  // assertion helpers
  // --------------------------------------------------------------------------

  // cycles since hold_req last stood high, saturating just past the stretch
  logic [CNT_W-1:0] quiet;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      quiet <= '0;
    end else if (hold_req) begin
      quiet <= '0;
    end else if (quiet <= CNT_W'(STRETCH_CYCLES)) begin
      quiet <= CNT_W'(quiet + 32'h1);
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------

  default clocking cb @(posedge i_sys_clk);
  endclocking

  default disable iff (!i_rst_b);

  sequence s_kick;
    kick_edge ##1 !supply_s;
  endsequence

  sequence s_supply_back;
    $fell(supply_s);
  endsequence

  a_reset_supply_low: assert property (supply_s |=> !o_reset_n)
    else $error("reset not low while supply low");

  a_reset_stretch_len: assert property ($rose(o_reset_n) |-> quiet == CNT_W'(STRETCH_CYCLES + 1))
    else $error("reset released after wrong stretch length");

  a_reset_manual_in: assert property (!mr_n_s |=> !o_reset_n ##1 !o_reset_n)
    else $error("manual reset did not hold reset low");

  a_reset_bounce_hold: assert property (quiet <= CNT_W'(STRETCH_CYCLES) |-> !o_reset_n)
    else $error("reset released inside stretch period");

  a_reset_complement: assert property (o_reset == !o_reset_n)
    else $error("reset outputs not complementary");

  a_wdog_timeout_low: assert property (wd_expired && !supply_s |=> !o_watchdog_expired_n)
    else $error("watchdog expiry not shown");

  a_wdog_kick_clear: assert property (s_kick |=> o_watchdog_expired_n)
    else $error("kick did not clear watchdog");

  a_wdog_reset_clear: assert property (rst_act |=> !wd_expired)
    else $error("watchdog counts during reset");

  a_wdog_float_off: assert property (float_s |=> !wd_expired)
    else $error("floating kick did not disable watchdog");

  a_wdo_supply_low: assert property (supply_s |=> !o_watchdog_expired_n)
    else $error("watchdog output not forced low on low supply");

  a_wdo_supply_back: assert property (s_supply_back |=> o_watchdog_expired_n && !o_reset_n)
    else $error("watchdog output not released on supply recovery");

  a_no_wdog_reset: assert property (!hold_req && stretch_done |=> o_reset_n)
    else $error("reset asserted without supply or manual cause");

  a_power_fail_out: assert property (o_power_fail_out_n == !$past(pf_below_s))
    else $error("power fail output wrong");

endmodule

`default_nettype wire

/* testbench/ssw_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// host processor: kicks the watchdog, stalls, or leaves the kick pin floating
// ----------------------------------------------------------------------------
module ssw_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic [1:0] i_mode,
  input  wire logic [7:0] i_period,
  output logic            o_kick,
  output logic            o_float
);
  logic [7:0] cnt;

  // mode 0 kicks every i_period cycles, 1 stalls, 2 floats the pin
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt     <= 8'h00;
      o_kick  <= 1'h0;
      o_float <= 1'h0;
    end else begin
      o_float <= (i_mode == 2'h2);
      if (i_mode == 2'h2) begin
        // a floating pin has no level of its own, so let it wander
        o_kick <= ~o_kick;
        cnt    <= 8'h00;
      end else if (i_mode == 2'h1) begin
        cnt <= 8'h00;
      end else if (cnt >= i_period - 8'h01) begin
        o_kick <= ~o_kick;
        cnt    <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

/* testbench/test_supply_supervisor_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none

module test_supply_supervisor_watchdog;
  // short counts keep the run brief; the stretch and timeout expectations derive from these
  localparam int unsigned SC = 20;
  localparam int unsigned WC = 50;

  logic        clk, rst_b, supply_low, man_n, pf_sense, kick, kfloat;
  logic        rst_n, rst, wdo_n, pfo_n;
  logic [1:0]  mode;
  logic [7:0]  period;
  logic [31:0] seed;
  int          miscompares, checks_done, n, m;

  ssw_top #(.STRETCH_CYCLES(SC), .WDOG_CYCLES(WC)) DUT (
    .i_sys_clk             (clk),
    .i_rst_b               (rst_b),
    .i_supply_low          (supply_low),
    .i_manual_reset_n      (man_n),
    .i_watchdog_kick_in    (kick),
    .i_watchdog_kick_float (kfloat),
    .i_power_fail_sense_in (pf_sense),
    .o_reset_n             (rst_n),
    .o_reset               (rst),
    .o_watchdog_expired_n  (wdo_n),
    .o_power_fail_out_n    (pfo_n)
  );

  ssw_host_model host (
    .i_sys_clk (clk),
    .i_rst_b   (rst_b),
    .i_mode    (mode),
    .i_period  (period),
    .o_kick    (kick),
    .o_float   (kfloat)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR t=%0t cycles %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  // step past each edge by the same small delay, so inputs change off the edge
  task automatic cyc(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
      check_bit(rst, ~rst_n);
    end
  endtask

  // bounded wait for a level; sel picks the watchdog flag instead of reset
  task automatic wait_out(input logic sel, input logic v, input int lim, output int k);
    k = 0;
    while ((sel ? wdo_n : rst_n) !== v) begin
      cyc(1);
      k++;
      if (k > lim) begin
        miscompares++;
        $display("ERROR t=%0t wait ran out, got %h exp %h", $time, sel ? wdo_n : rst_n, v);
        complete_run();
      end
    end
  endtask

  initial begin
    clk = 0; rst_b = 0; supply_low = 1; man_n = 1; pf_sense = 0;
    mode = 2'h0; period = 8'h08; seed = 32'h00012ba5;
    miscompares = 0; checks_done = 0;
    repeat (4) @(posedge clk);
    #1 rst_b = 1;
    // supply low holds both outputs low, then recovery and stretch
    cyc(30);
    check_bit(rst_n, 1'h0);
    check_bit(wdo_n, 1'h0);
    supply_low = 0;
    wait_out(1, 1, 4, n);
    check_count(n, 2, 3);
    check_bit(rst_n, 1'h0);
    wait_out(0, 1, SC + 10, m);
    check_count(n + m, SC + 2, SC + 4);
    $display("test supply recovery done");
    // manual reset with a bouncing release
    man_n = 0;
    wait_out(0, 0, 4, n);
    check_count(n, 2, 3);
    repeat (3) begin
      seed = xorshift(seed);
      man_n = 1;
      cyc(1 + int'(seed % 32'h8));
      man_n = 0;
      cyc(2);
      check_bit(rst_n, 1'h0);
    end
    man_n = 1;
    wait_out(0, 1, SC + 10, n);
    check_count(n, SC + 2, SC + 4);
    $display("test manual reset done");
    // random kick intervals below the timeout keep the flag high
    repeat (30) begin
      seed = xorshift(seed);
      period = 8'h04 + 8'(seed % 32'h24);
      cyc(10);
      check_bit(wdo_n, 1'h1);
    end
    // stall right after a kick edge
    n = 0;
    m = int'(kick);
    while (int'(kick) == m && n < 64) begin
      cyc(1);
      n++;
    end
    mode = 2'h1;
    wait_out(1, 0, WC + 10, n);
    check_count(n, WC + 1, WC + 5);
    repeat (8) begin
      cyc(10);
      check_bit(wdo_n, 1'h0);
      check_bit(rst_n, 1'h1);
    end
    mode = 2'h0;
    wait_out(1, 1, 60, n);
    check_bit(wdo_n, 1'h1);
    $display("test watchdog expiry done");
    // floating pin: never expires
    mode = 2'h2;
    repeat (20) begin
      cyc(10);
      check_bit(wdo_n, 1'h1);
    end
    $display("test floating kick done");
    // counter near expiry is cleared by a reset; timing restarts at release
    mode = 2'h1;
    cyc(WC - 10);
    check_bit(wdo_n, 1'h1);
    man_n = 0;
    cyc(5);
    man_n = 1;
    wait_out(0, 1, SC + 10, n);
    wait_out(1, 0, WC + 10, n);
    check_count(n, WC - 2, WC + 3);
    mode = 2'h0;
    // the flag is still low from the stall; kicks must raise it before the drop
    wait_out(1, 1, 60, n);
    check_bit(wdo_n, 1'h1);
    $display("test watchdog reset clear done");
    // supply drop mid-run forces the flag low within 2 to 3 cycles
    supply_low = 1;
    wait_out(1, 0, 4, n);
    check_count(n, 2, 3);
    check_bit(rst_n, 1'h0);
    supply_low = 0;
    // random comparator levels
    repeat (40) begin
      seed = xorshift(seed);
      pf_sense = seed[3];
      cyc(4);
      check_bit(pfo_n, ~pf_sense);
    end
    $display("test power fail done");
    complete_run();
  end
endmodule

`default_nettype wire
